// ---- rtl/evt_status_pkg.sv ----
// Constants and carrier types for the pin and timing event status block
package evt_status_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int PIN_N = 7;
    localparam int UPPER_FIRST_PIN = 3;
    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_PIN_MODE_ONE = 6'h01;
    localparam logic [5:0] IDX_PIN_MODE_TWO = 6'h02;
    localparam logic [5:0] IDX_PIN_STATUS = 6'h03;
    localparam logic [5:0] IDX_EVT_FLAGS = 6'h04;
    localparam logic [5:0] IDX_EVT_ENABLE = 6'h05;
    // Reset values
    localparam logic [15:0] RST_PIN_MODE_ONE = 16'h0000;
    localparam logic [15:0] RST_PIN_MODE_TWO = 16'h0000;
    localparam logic [15:0] RST_EVT_ENABLE = 16'h0000;
    // Writable bits of the read-write registers
    localparam logic [15:0] MASK_PIN_MODE_ONE = 16'h7fff;
    localparam logic [15:0] MASK_PIN_MODE_TWO = 16'h3fff;
    localparam logic [15:0] MASK_EVT_ENABLE = 16'h3fff;
    // Field positions
    localparam int UPPER_SEL_BIT = 13;
    localparam int LOWER_SEL_BIT = 12;
    localparam int PIN_LATCH_LSB = 8;
    localparam int PIN_LEVEL_LSB = 0;
    localparam int SUMMARY_BIT = 14;
    localparam int IRQ_PIN_SEL_LSB = 0;
    localparam logic [2:0] IRQ_PIN_MODE = 3'h5;
    // Timing event bit positions
    localparam int BIT_TIME_ADJ = 0;
    localparam int BIT_GEN1_EVT = 1;
    localparam int BIT_GEN1_SEQ = 2;
    localparam int BIT_GEN1_FREE = 3;
    localparam int BIT_GEN2_EVT = 4;
    localparam int BIT_GEN2_SEQ = 5;
    localparam int BIT_GEN2_FREE = 6;
    localparam int BIT_STAMP1_FILLED = 8;
    localparam int BIT_STAMP1_OVFL = 9;
    localparam int STAMP_STRIDE = 2;
    localparam int GEN_STRIDE = 3;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [3:0] pstrb;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

    // Index 0 is timestamp FIFO one or event generator one
    typedef struct packed {
        logic [2:0] stamp_overflow;
        logic [2:0] stamp_not_empty;
        logic [1:0] gen_fifo_full;
        logic [1:0] gen_sequence_done;
        logic [1:0] gen_event_done;
        logic [1:0] gen_event_marked;
        logic time_adjust_done;
    } timing_events_t;
endpackage

// ---- rtl/read_clear_flags.sv ----
// Bank of latch-high flags cleared selectively by a register read
`timescale 1ns/1ps
`default_nettype none
module read_clear_flags #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] set_vec,
    input wire logic [W-1:0] clr_vec,
    output logic [W-1:0] flags
);
    logic [W-1:0] flags_ff;
    logic [W-1:0] nxt_flags;

    // Only the bits software actually saw are cleared; a new event wins
    assign nxt_flags = (flags_ff & ~clr_vec) | set_vec;
    assign flags = flags_ff;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            flags_ff <= '0;
        end
        else
        begin
            flags_ff <= nxt_flags;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/event_status_top.sv ----
// Pin edge status and timing event interrupt collection behind APB
//
// Summary of operation
// - Pins four-seven latch chosen edge, bits 14:11
// - Pins one-three latch chosen edge, bits 10:8
// - Latched flags report event since read
// - Live pin levels in bits 6:0
// - Summary bit 14 ORs enabled latched events
// - Combined interrupt can drive a pin
// - Stamp FIFO overflow latches bits 13,11,9
// - Stamp FIFO empty-to-filled latches 12,10,8
// - Generator FIFO full-to-not-full latches 6,3
// - Generator sequence done latches 5,2
// - Marked generator event done latches 4,1
// - Time adjustment done latches bit 0
// - Flag sets on event, clears on read
// - Edge select: 0 falling, 1 rising
// - Per-flag enable gates the summary
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module event_status_top (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire evt_status_pkg::apb_req_t apb_req,
    output var evt_status_pkg::apb_rsp_t apb_rsp,
    input wire logic [evt_status_pkg::PIN_N-1:0] pin_level_in,
    input wire evt_status_pkg::timing_events_t timing_evt,
    output logic irq_pin_out,
    output logic irq_pin_oe
);
    localparam int PN = evt_status_pkg::PIN_N;
    localparam int RW = evt_status_pkg::REG_W;

    // True when the APB byte address selects the register at this index
    // Unaligned byte addresses never match, so they are refused
    function automatic logic reg_hit(
        input logic [evt_status_pkg::ADDR_W-1:0] addr,
        input logic [5:0] idx
    );
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // Byte-lane merge for the low half of the data bus
    // Read-only bits keep their stored value whatever the strobes say
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0] strb,
        input logic [15:0] wmask
    );
        logic [15:0] merged;
        merged = old_val;
        if (strb[0])
        begin
            merged[7:0] = new_val[7:0];
        end
        if (strb[1])
        begin
            merged[15:8] = new_val[15:8];
        end
        lane_merge = (merged & wmask) | (old_val & ~wmask);
    endfunction

    // Picks the transition that a group's select asks for: 0 falling, 1 rising
    function automatic logic edge_pick(
        input logic rise,
        input logic fall,
        input logic sel
    );
        edge_pick = sel ? rise : fall;
    endfunction

    // Registers
    logic [RW-1:0] mode_one_ff;
    logic [RW-1:0] mode_two_ff;
    logic [RW-1:0] enable_ff;
    logic [PN-1:0] pin_prev_ff;
    logic [2:0] filled_prev_ff;
    logic [1:0] full_prev_ff;
    logic primed_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [evt_status_pkg::DATA_W-1:0] prdata_ff;
    logic irq_pin_out_ff;
    logic irq_pin_oe_ff;

    // Next values
    logic nxt_pready;
    logic nxt_pslverr;
    logic [evt_status_pkg::DATA_W-1:0] nxt_prdata;
    logic [RW-1:0] nxt_mode_one;
    logic [RW-1:0] nxt_mode_two;
    logic [RW-1:0] nxt_enable;

    // Every transfer spends two cycles in the access phase: the first edge
    // captures the read image, the second completes with pready high. The
    // image is taken a cycle early so that prdata comes straight from a flop.
    // APB phase decode
    wire access_phase = apb_req.psel & apb_req.penable;
    wire capture = access_phase & ~pready_ff;
    wire done = access_phase & pready_ff;
    wire wr_done = done & apb_req.pwrite;
    wire rd_done = done & ~apb_req.pwrite;

    wire hit_mode_one = reg_hit(apb_req.paddr, evt_status_pkg::IDX_PIN_MODE_ONE);
    wire hit_mode_two = reg_hit(apb_req.paddr, evt_status_pkg::IDX_PIN_MODE_TWO);
    wire hit_pin_status = reg_hit(apb_req.paddr, evt_status_pkg::IDX_PIN_STATUS);
    wire hit_evt_flags = reg_hit(apb_req.paddr, evt_status_pkg::IDX_EVT_FLAGS);
    wire hit_evt_enable = reg_hit(apb_req.paddr, evt_status_pkg::IDX_EVT_ENABLE);
    wire hit_any = hit_mode_one | hit_mode_two | hit_pin_status
        | hit_evt_flags | hit_evt_enable;

    // Pin edge detection; pins are taken as synchronous, so no synchroniser
    // stands in front of the previous-sample store
    wire upper_sel = mode_two_ff[evt_status_pkg::UPPER_SEL_BIT];
    wire lower_sel = mode_two_ff[evt_status_pkg::LOWER_SEL_BIT];
    wire [PN-1:0] pin_rise = pin_level_in & ~pin_prev_ff;
    wire [PN-1:0] pin_fall = ~pin_level_in & pin_prev_ff;
    logic [PN-1:0] pin_edge;

    genvar gi;
    generate
        for (gi = 0; gi < PN; gi++)
        begin : g_pin
            if (gi >= evt_status_pkg::UPPER_FIRST_PIN)
            begin : g_upper
                // Upper group follows its own select
                assign pin_edge[gi] = primed_ff
                    & edge_pick(pin_rise[gi], pin_fall[gi], upper_sel);
            end
            else
            begin : g_lower
                assign pin_edge[gi] = primed_ff
                    & edge_pick(pin_rise[gi], pin_fall[gi], lower_sel);
            end
        end
    endgenerate

    // Timing event set vector
    // Levels are edge-detected here; pulses pass straight through
    wire [2:0] filled_rise = timing_evt.stamp_not_empty & ~filled_prev_ff;
    wire [1:0] space_freed = ~timing_evt.gen_fifo_full & full_prev_ff;
    wire [1:0] marked_done = timing_evt.gen_event_done & timing_evt.gen_event_marked;
    logic [RW-1:0] evt_set;

    assign evt_set[evt_status_pkg::BIT_TIME_ADJ] = timing_evt.time_adjust_done;
    // Positions with no event source never set
    assign evt_set[7] = 1'b0;
    assign evt_set[15:14] = 2'b00;

    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_stamp
            localparam int NE_POS =
                evt_status_pkg::BIT_STAMP1_FILLED + gi * evt_status_pkg::STAMP_STRIDE;
            localparam int OF_POS =
                evt_status_pkg::BIT_STAMP1_OVFL + gi * evt_status_pkg::STAMP_STRIDE;
            // Level input: only the empty-to-filled step counts
            assign evt_set[NE_POS] = primed_ff & filled_rise[gi];
            // Overflow arrives as a pulse and latches as it comes
            assign evt_set[OF_POS] = timing_evt.stamp_overflow[gi];
        end
        for (gi = 0; gi < 2; gi++)
        begin : g_gen
            localparam int EVT_POS =
                evt_status_pkg::BIT_GEN1_EVT + gi * evt_status_pkg::GEN_STRIDE;
            localparam int SEQ_POS =
                evt_status_pkg::BIT_GEN1_SEQ + gi * evt_status_pkg::GEN_STRIDE;
            localparam int FREE_POS =
                evt_status_pkg::BIT_GEN1_FREE + gi * evt_status_pkg::GEN_STRIDE;
            // Unmarked completions are ignored
            assign evt_set[EVT_POS] = marked_done[gi];
            // Sequence completion is a pulse, so no edge detection
            assign evt_set[SEQ_POS] = timing_evt.gen_sequence_done[gi];
            assign evt_set[FREE_POS] = primed_ff & space_freed[gi];
        end
    endgenerate

    // Flag banks
    logic [PN-1:0] pin_flags;
    logic [RW-1:0] evt_flags;
    logic [PN-1:0] pin_clr;
    logic [RW-1:0] evt_clr;

    // A read clears only on its completing edge, never on a refused access
    wire pin_rd_clear = rd_done & hit_pin_status;
    wire evt_rd_clear = rd_done & hit_evt_flags;

    // The read data captured a cycle earlier decides which bits clear
    assign pin_clr = pin_rd_clear
        ? prdata_ff[evt_status_pkg::PIN_LATCH_LSB +: PN]
        : '0;
    assign evt_clr = evt_rd_clear
        ? {2'b00, prdata_ff[13:0]}
        : '0;

    read_clear_flags #(
        .W(PN)
    ) u_pin_flags (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .set_vec(pin_edge),
        .clr_vec(pin_clr),
        .flags(pin_flags)
    );

    read_clear_flags #(
        .W(RW)
    ) u_evt_flags (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .set_vec(evt_set),
        .clr_vec(evt_clr),
        .flags(evt_flags)
    );

    // Summary is combinational over the latched flags, never latched itself
    // The pin output follows one edge later, from its own flop
    wire summary = |(evt_flags & enable_ff);

    // Read images
    // Reserved positions read low: tied in the images, except event flag bit 7, a stored flag that never sets
    wire [RW-1:0] pin_status_img = {1'b0, pin_flags, 1'b0, pin_level_in};
    wire [RW-1:0] evt_flags_img = {1'b0, summary, evt_flags[13:0]};

    always_comb
    begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (capture)
        begin
            nxt_pslverr = ~hit_any;
            nxt_prdata = '0;
            if (!apb_req.pwrite)
            begin
                unique case (1'b1)
                    hit_mode_one: nxt_prdata[RW-1:0] = mode_one_ff;
                    hit_mode_two: nxt_prdata[RW-1:0] = mode_two_ff;
                    hit_pin_status: nxt_prdata[RW-1:0] = pin_status_img;
                    hit_evt_flags: nxt_prdata[RW-1:0] = evt_flags_img;
                    hit_evt_enable: nxt_prdata[RW-1:0] = enable_ff;
                    default: nxt_prdata = '0;
                endcase
            end
        end
        else if (done)
        begin
            nxt_pslverr = 1'b0;
        end
    end

    assign nxt_pready = capture;

    // Register writes take effect on the completing edge only
    assign nxt_mode_one = (wr_done & hit_mode_one)
        ? lane_merge(mode_one_ff, apb_req.pwdata[15:0], apb_req.pstrb[1:0],
            evt_status_pkg::MASK_PIN_MODE_ONE)
        : mode_one_ff;
    assign nxt_mode_two = (wr_done & hit_mode_two)
        ? lane_merge(mode_two_ff, apb_req.pwdata[15:0], apb_req.pstrb[1:0],
            evt_status_pkg::MASK_PIN_MODE_TWO)
        : mode_two_ff;
    assign nxt_enable = (wr_done & hit_evt_enable)
        ? lane_merge(enable_ff, apb_req.pwdata[15:0], apb_req.pstrb[1:0],
            evt_status_pkg::MASK_EVT_ENABLE)
        : enable_ff;

    // Only the lowest mode field of the first pin control register can route
    // the interrupt; any other code leaves the pin undriven
    wire irq_pin_selected = mode_one_ff[evt_status_pkg::IRQ_PIN_SEL_LSB +: 3]
        == evt_status_pkg::IRQ_PIN_MODE;

    // Software-written controls
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            mode_one_ff <= evt_status_pkg::RST_PIN_MODE_ONE;
            mode_two_ff <= evt_status_pkg::RST_PIN_MODE_TWO;
            enable_ff <= evt_status_pkg::RST_EVT_ENABLE;
        end
        else
        begin
            mode_one_ff <= nxt_mode_one;
            mode_two_ff <= nxt_mode_two;
            enable_ff <= nxt_enable;
        end
    end

    // Previous-sample stores; primed_ff suppresses false edges after reset
    // Without it a level already high at release would read as a fresh edge
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pin_prev_ff <= '0;
            filled_prev_ff <= '0;
            full_prev_ff <= '0;
            primed_ff <= 1'b0;
        end
        else
        begin
            pin_prev_ff <= pin_level_in;
            filled_prev_ff <= timing_evt.stamp_not_empty;
            full_prev_ff <= timing_evt.gen_fifo_full;
            primed_ff <= 1'b1;
        end
    end

    // Bus response flops; pslverr stands only while pready does
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // Pin driven only in interrupt mode; a disabled pin is left undriven
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            irq_pin_out_ff <= 1'b0;
            irq_pin_oe_ff <= 1'b0;
        end
        else
        begin
            irq_pin_out_ff <= summary;
            irq_pin_oe_ff <= irq_pin_selected;
        end
    end

    assign apb_rsp.pready = pready_ff;
    assign apb_rsp.pslverr = pslverr_ff;
    assign apb_rsp.prdata = prdata_ff;
    assign irq_pin_out = irq_pin_out_ff;
    assign irq_pin_oe = irq_pin_oe_ff;
endmodule
`default_nettype wire

// ---- tb/event_status_properties.sv ----
// Port-level assertions for the pin and timing event status block
`timescale 1ns/1ps
`default_nettype none
module event_status_properties (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire evt_status_pkg::apb_req_t apb_req,
    input wire evt_status_pkg::apb_rsp_t apb_rsp,
    input wire logic [evt_status_pkg::PIN_N-1:0] pin_level_in,
    input wire evt_status_pkg::timing_events_t timing_evt,
    input wire logic irq_pin_out,
    input wire logic irq_pin_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence cap_s;
        apb_req.psel && apb_req.penable && !apb_rsp.pready;
    endsequence
    sequence done_s;
        apb_req.psel && apb_req.penable && apb_rsp.pready;
    endsequence
    answer_time_a: assert property (cap_s |=> apb_rsp.pready)
        else $error("ready not one cycle after capture");
    ready_pulse_a: assert property (done_s |=> !apb_rsp.pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error without ready");
    unmapped_err_a: assert property (cap_s ##0 (apb_req.paddr == 8'h40)
        |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    live_level_a: assert property (cap_s ##0 (apb_req.paddr == 8'h0c)
        |=> apb_rsp.prdata[6:0] == $past(pin_level_in))
        else $error("pin level image wrong");
    reserved_zero_a: assert property (done_s ##0 (apb_req.paddr inside {8'h0c, 8'h10})
        |-> apb_rsp.prdata[31:15] == 17'h0 && !apb_rsp.prdata[7])
        else $error("reserved bit set");
    reset_quiet_a: assert property (disable iff (1'b0) sys_rst
        |=> !apb_rsp.pready && !irq_pin_out && !irq_pin_oe)
        else $error("outputs active after reset");
    // The control register updates on the completing edge, the pin enable flop one edge later
    oe_follow_a: assert property (done_s ##0 (apb_req.pwrite && apb_req.paddr == 8'h04
        && apb_req.pstrb[0]) |-> ##2 (irq_pin_oe == ($past(apb_req.pwdata[2:0], 2) == 3'h5)))
        else $error("interrupt pin enable wrong");
endmodule
bind event_status_top event_status_properties u_props (.mclk(mclk), .sys_rst(sys_rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_level_in(pin_level_in),
    .timing_evt(timing_evt), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
`default_nettype wire

// ---- tb/tb.sv ----
// Register-level testbench for the pin and timing event status block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] A_M1 = 8'h04;
    localparam logic [7:0] A_M2 = 8'h08;
    localparam logic [7:0] A_ST = 8'h0c;
    localparam logic [7:0] A_FL = 8'h10;
    localparam logic [7:0] A_EN = 8'h14;
    logic mclk;
    logic sys_rst;
    evt_status_pkg::apb_req_t req;
    evt_status_pkg::apb_rsp_t rsp;
    evt_status_pkg::timing_events_t tev;
    logic [6:0] pins;
    logic irq;
    logic oe;
    int error_cnt = 0;
    int n_compared = 0;
    int eb[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 11, 12, 13};
    logic [15:0] lp;
    logic [15:0] mup;
    logic [3:0] strb = 4'h3;

    event_status_top uut (.mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
        .pin_level_in(pins), .timing_evt(tev), .irq_pin_out(irq), .irq_pin_oe(oe));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask

    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [15:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pstrb: strb,
            pwdata: {16'h0, d}};
        @(posedge mclk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            test_done();
        end
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask

    // Error flag is folded into bit 16 so one compare covers data and response
    task automatic chk(input logic [7:0] a, input logic [15:0] x, input logic ee);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 16'h0, r, e);
        cmp($sformatf("reg %h", a), {15'h0, ee, x}, r | {15'h0, e, 16'h0});
    endtask

    task automatic fire(input int b, input logic mk);
        evt_status_pkg::timing_events_t t;
        t = '0;
        case (b)
            0: t.time_adjust_done = 1'b1;
            1, 4:
            begin
                t.gen_event_done[b/3] = 1'b1;
                t.gen_event_marked[b/3] = mk;
            end
            2, 5: t.gen_sequence_done[b/3] = 1'b1;
            3, 6: t.gen_fifo_full[b/3-1] = 1'b1;
            8, 10, 12: t.stamp_not_empty[(b-8)/2] = 1'b1;
            default: t.stamp_overflow[(b-9)/2] = 1'b1;
        endcase
        @(posedge mclk);
        tev <= t;
        @(posedge mclk);
        tev <= '0;
    endtask

    initial
    begin
        sys_rst = 1'b1;
        req = '0;
        tev = '0;
        pins = '0;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        foreach (eb[i])
            if (i < 5)
                chk(8'(4 * (i + 1)), 16'h0, 1'b0);
        wr(A_M1, 16'hffff);
        wr(A_M2, 16'hffff);
        wr(A_EN, 16'hffff);
        wr(A_ST, 16'hffff);
        wr(A_FL, 16'hffff);
        chk(A_M1, evt_status_pkg::MASK_PIN_MODE_ONE, 1'b0);
        chk(A_M2, evt_status_pkg::MASK_PIN_MODE_TWO, 1'b0);
        chk(A_EN, evt_status_pkg::MASK_EVT_ENABLE, 1'b0);
        // High lane only: the low byte must keep its value
        strb = 4'h2;
        wr(A_EN, 16'h0000);
        strb = 4'h3;
        chk(A_EN, 16'h00ff, 1'b0);
        chk(A_FL, 16'h0, 1'b0);
        chk(8'h40, 16'h0, 1'b1);
        chk(8'h11, 16'h0, 1'b1);
        wr(A_M1, 16'h0);
        wr(A_EN, 16'h0);
        for (int s = 0; s < 4; s++)
        begin
            wr(A_M2, 16'(s) << 12);
            mup = (s[1] ? 16'h7800 : 16'h0) | (s[0] ? 16'h0700 : 16'h0);
            lp = {1'b0, 7'h5a, 8'h0};
            @(posedge mclk);
            pins <= 7'h5a;
            chk(A_ST, {9'h0, 7'h5a} | (lp & mup), 1'b0);
            @(posedge mclk);
            pins <= 7'h00;
            chk(A_ST, lp & ~mup, 1'b0);
        end
        chk(A_ST, 16'h0, 1'b0);
        foreach (eb[i])
        begin
            fire(eb[i], 1'b1);
            chk(A_FL, 16'h1 << eb[i], 1'b0);
            chk(A_FL, 16'h0, 1'b0);
        end
        fire(1, 1'b0);
        fire(4, 1'b0);
        chk(A_FL, 16'h0, 1'b0);
        @(posedge mclk);
        tev.stamp_not_empty <= 3'h7;
        chk(A_FL, 16'h1500, 1'b0);
        chk(A_FL, 16'h0, 1'b0);
        tev <= '0;
        wr(A_EN, 16'h0001);
        wr(A_M1, 16'h0005);
        fire(0, 1'b1);
        repeat (2) @(posedge mclk);
        cmp("irq", 32'h3, {30'h0, oe, irq});
        chk(A_FL, 16'h4001, 1'b0);
        repeat (3) @(posedge mclk);
        cmp("irq", 32'h2, {30'h0, oe, irq});
        wr(A_EN, 16'h3ffe);
        fire(0, 1'b1);
        repeat (2) @(posedge mclk);
        cmp("irq", 32'h2, {30'h0, oe, irq});
        fork
            chk(A_FL, 16'h0001, 1'b0);
            begin
                repeat (3) @(posedge mclk);
                tev.time_adjust_done <= 1'b1;
                @(posedge mclk);
                tev.time_adjust_done <= 1'b0;
            end
        join
        chk(A_FL, 16'h0001, 1'b0);
        chk(A_FL, 16'h0, 1'b0);
        wr(A_M1, 16'h0);
        repeat (3) @(posedge mclk);
        cmp("oe", 32'h0, {31'h0, oe});
        // Mid-run reset with a flag pending and a fill level held high across it
        fire(9, 1'b1);
        @(posedge mclk);
        tev.stamp_not_empty <= 3'h7;
        sys_rst <= 1'b1;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        chk(A_FL, 16'h0, 1'b0);
        chk(A_M2, 16'h0, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
